// ===== include/lssb_params.svh
// register indices, bit positions and reset values of the status bank
`ifndef LSSB_PARAMS_SVH
`define LSSB_PARAMS_SVH

`define LSSB_IDX_LOOP1 10'h117
`define LSSB_IDX_LOOP2 10'h118
`define LSSB_IDX_LOOP3 10'h119
`define LSSB_IDX_REF01 10'h126
`define LSSB_IDX_REF23 10'h127
`define LSSB_IDX_SYNTH_ZERO 10'h16E
`define LSSB_IDX_IRQ_ST 10'h180
`define LSSB_IDX_IRQ_MASK 10'h181

`define LSSB_B_SLOPE 7
`define LSSB_B_MEM 6
`define LSSB_B_RANGE 5
`define LSSB_B_HOLD 1
`define LSSB_B_UNLOCK 0
`define LSSB_B_ALIGN_B 5
`define LSSB_B_ALIGN_A 4
`define LSSB_B_SYN_UNLOCK 2

`define LSSB_IRQ_UNL_BASE 0
`define LSSB_IRQ_HOLD_BASE 3
`define LSSB_IRQ_SYN_UNL 6
`define LSSB_IRQ_ALIGN 7

`define LSSB_RST_BYTE 8'h00
`define LSSB_RST_WORD 32'h0000_0000

`endif

// ===== include/lssb_pkg.sv
// types carried between the monitors and the status bank
package lssb_pkg;

	typedef logic [3:0] lssb_ref_t;

	typedef struct packed {
		logic slope_hit;
		logic mem_hit;
		logic range_hit;
		logic holdover;
		logic unlocked;
	} lssb_loop_health_t;

	typedef struct packed {
		logic enable;
		logic out_a_enable;
		logic out_b_enable;
		logic align_done_a;
		logic align_done_b;
		logic unlocked;
	} lssb_synth_mon_t;

	typedef struct packed {
		lssb_loop_health_t [2:0] loops;
		lssb_ref_t [3:0] refs;
		lssb_synth_mon_t synth;
	} lssb_mon_t;

endpackage

// ===== src/lssb_sync3.sv
// three-stage input filter, a bit changes once stages two and three agree
`timescale 1ns/1ps
module lssb_sync3 #(
	parameter int W = 37
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] q_ff;
	logic [W-1:0] nxt_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i];
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			q_ff <= '0;
		end else begin
			s1_ff <= d_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			q_ff <= nxt_q;
		end
	end

	assign q_o = q_ff;
endmodule

// ===== src/lssb_top.sv
// loop and synthesizer status bank behind an apb slave, read-only except the interrupt status and mask
`timescale 1ns/1ps
`include "lssb_params.svh"
module lssb_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// monitor flags
	input wire lssb_pkg::lssb_mon_t mon_i,
	// interrupt
	output logic irq_o
);
	lssb_pkg::lssb_mon_t mon_f;
	logic [2:0][7:0] loop_ff;
	logic [2:0][7:0] nxt_loop;
	logic [7:0] ref01_ff;
	logic [7:0] ref23_ff;
	logic [7:0] synth_ff;
	logic [7:0] irq_st_ff;
	logic [7:0] irq_mask_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic [7:0] nxt_ref01;
	logic [7:0] nxt_ref23;
	logic [7:0] nxt_synth;
	logic [7:0] nxt_irq_st;
	logic [7:0] nxt_irq_mask;
	logic [31:0] nxt_prdata;
	logic [7:0] ev;
	logic [2:0] ev_unl;
	logic [2:0] ev_hold;

	lssb_sync3 #(
		.W($bits(lssb_pkg::lssb_mon_t))
	) u_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.d_i(mon_i),
		.q_o(mon_f)
	);

	// apb decode
	wire [9:0] idx = paddr_i[11:2];
	wire setup = psel_i & ~penable_i;
	wire wr_acc = psel_i & penable_i & pwrite_i;
	wire hit_l1 = (idx == `LSSB_IDX_LOOP1);
	wire hit_l2 = (idx == `LSSB_IDX_LOOP2);
	wire hit_l3 = (idx == `LSSB_IDX_LOOP3);
	wire hit_r01 = (idx == `LSSB_IDX_REF01);
	wire hit_r23 = (idx == `LSSB_IDX_REF23);
	wire hit_syn = (idx == `LSSB_IDX_SYNTH_ZERO);
	wire hit_ist = (idx == `LSSB_IDX_IRQ_ST);
	wire hit_imk = (idx == `LSSB_IDX_IRQ_MASK);
	wire hit_any = hit_l1 | hit_l2 | hit_l3 | hit_r01 | hit_r23 | hit_syn |
		hit_ist | hit_imk;
	wire [7:0] rd_byte = ({8{hit_l1}} & loop_ff[0]) |
		({8{hit_l2}} & loop_ff[1]) |
		({8{hit_l3}} & loop_ff[2]) |
		({8{hit_r01}} & ref01_ff) |
		({8{hit_r23}} & ref23_ff) |
		({8{hit_syn}} & synth_ff) |
		({8{hit_ist}} & irq_st_ff) |
		({8{hit_imk}} & irq_mask_ff);
	assign nxt_prdata = setup ? {24'h00_0000, rd_byte} : prdata_ff;
	wire w1c_en = wr_acc & hit_ist;
	wire mask_en = wr_acc & hit_imk;

	// per-loop health bytes, writes never reach them
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_loop
			always_comb begin
				nxt_loop[i] = `LSSB_RST_BYTE;
				nxt_loop[i][`LSSB_B_SLOPE] = mon_f.loops[i].slope_hit;
				nxt_loop[i][`LSSB_B_MEM] = mon_f.loops[i].mem_hit;
				nxt_loop[i][`LSSB_B_RANGE] = mon_f.loops[i].range_hit;
				nxt_loop[i][`LSSB_B_HOLD] = mon_f.loops[i].holdover;
				nxt_loop[i][`LSSB_B_UNLOCK] = mon_f.loops[i].unlocked;
			end
			assign ev_unl[i] = mon_f.loops[i].unlocked &
				~loop_ff[i][`LSSB_B_UNLOCK];
			assign ev_hold[i] = mon_f.loops[i].holdover &
				~loop_ff[i][`LSSB_B_HOLD];
		end
	endgenerate

	// chosen references
	assign nxt_ref01 = {mon_f.refs[1], mon_f.refs[0]};
	assign nxt_ref23 = {mon_f.refs[3], mon_f.refs[2]};

	// synthesizer zero, alignment held at zero while disabled
	wire align_a = mon_f.synth.align_done_a & mon_f.synth.out_a_enable &
		mon_f.synth.enable;
	wire align_b = mon_f.synth.align_done_b & mon_f.synth.out_b_enable &
		mon_f.synth.enable;
	always_comb begin
		nxt_synth = `LSSB_RST_BYTE;
		nxt_synth[`LSSB_B_ALIGN_A] = align_a;
		nxt_synth[`LSSB_B_ALIGN_B] = align_b;
		nxt_synth[`LSSB_B_SYN_UNLOCK] = mon_f.synth.unlocked;
	end

	// interrupt events, set wins over a write-one clear
	always_comb begin
		ev = 8'h00;
		ev[`LSSB_IRQ_UNL_BASE +: 3] = ev_unl;
		ev[`LSSB_IRQ_HOLD_BASE +: 3] = ev_hold;
		ev[`LSSB_IRQ_SYN_UNL] = mon_f.synth.unlocked &
			~synth_ff[`LSSB_B_SYN_UNLOCK];
		ev[`LSSB_IRQ_ALIGN] = (align_a & ~synth_ff[`LSSB_B_ALIGN_A]) |
			(align_b & ~synth_ff[`LSSB_B_ALIGN_B]);
	end
	assign nxt_irq_st = (irq_st_ff & ~({8{w1c_en}} & pwdata_i[7:0])) | ev;
	assign nxt_irq_mask = mask_en ? pwdata_i[7:0] : irq_mask_ff;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			loop_ff <= '0;
			ref01_ff <= `LSSB_RST_BYTE;
			ref23_ff <= `LSSB_RST_BYTE;
			synth_ff <= `LSSB_RST_BYTE;
			irq_st_ff <= `LSSB_RST_BYTE;
			irq_mask_ff <= `LSSB_RST_BYTE;
			prdata_ff <= `LSSB_RST_WORD;
			pslverr_ff <= 1'b0;
		end else begin
			loop_ff <= nxt_loop;
			ref01_ff <= nxt_ref01;
			ref23_ff <= nxt_ref23;
			synth_ff <= nxt_synth;
			irq_st_ff <= nxt_irq_st;
			irq_mask_ff <= nxt_irq_mask;
			prdata_ff <= nxt_prdata;
			pslverr_ff <= setup ? ~hit_any : pslverr_ff;
		end
	end

	assign prdata_o = prdata_ff;
	assign pready_o = 1'b1;
	assign pslverr_o = pslverr_ff & psel_i & penable_i;
	assign irq_o = |(irq_st_ff & irq_mask_ff);

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_loop_slope_bit: assert property (
		mon_f.loops[0].slope_hit |=> loop_ff[0][7])
		else $error("loop 1 slope flag not in bit 7");
	a_loop_mem_bit: assert property (
		!mon_f.loops[1].mem_hit |=> !loop_ff[1][6])
		else $error("loop 2 memory flag wrong");
	a_loop_range_bit: assert property (
		$rose(mon_f.loops[2].range_hit) |=> loop_ff[2][5])
		else $error("loop 3 range flag not in bit 5");
	a_loop_hold_unl: assert property (
		##1 loop_ff[0][1:0] ==
		$past({mon_f.loops[0].holdover, mon_f.loops[0].unlocked}))
		else $error("loop 1 holdover or unlock bits wrong");
	a_ref_lower_pair: assert property (
		##1 ref01_ff == {$past(mon_f.refs[1]), $past(mon_f.refs[0])})
		else $error("loop 0/1 reference nibbles wrong");
	a_ref_upper_pair: assert property (
		##1 ref23_ff[7:4] == $past(mon_f.refs[3]))
		else $error("loop 3 reference nibble wrong");
	a_align_disable_clear: assert property (
		!mon_f.synth.enable |=> !synth_ff[4] && !synth_ff[5])
		else $error("alignment flag survives disable");
	a_synth_unlock_bit: assert property (
		$changed(mon_f.synth.unlocked) |=>
		synth_ff[2] == $past(mon_f.synth.unlocked))
		else $error("synthesizer unlock bit wrong");
	a_reserved_zero: assert property (
		loop_ff[0][4:2] == 3'h0 && synth_ff[7:6] == 2'h0 &&
		synth_ff[3] == 1'b0 && synth_ff[1:0] == 2'h0)
		else $error("reserved bit nonzero");
	a_read_word: assert property (
		setup && hit_syn |=> prdata_o == {24'h00_0000, $past(synth_ff)})
		else $error("read data not the addressed byte");

	// per-loop bit placement
	a_loop2_slope_bit: assert property (
		##1 loop_ff[1][7] == $past(mon_f.loops[1].slope_hit))
		else $error("loop 2 slope flag not in bit 7");
	a_loop3_slope_bit: assert property (
		##1 loop_ff[2][7] == $past(mon_f.loops[2].slope_hit))
		else $error("loop 3 slope flag not in bit 7");
	a_loop1_mem_bit: assert property (
		##1 loop_ff[0][6] == $past(mon_f.loops[0].mem_hit))
		else $error("loop 1 memory flag not in bit 6");
	a_loop3_mem_bit: assert property (
		##1 loop_ff[2][6] == $past(mon_f.loops[2].mem_hit))
		else $error("loop 3 memory flag not in bit 6");
	a_loop1_range_bit: assert property (
		##1 loop_ff[0][5] == $past(mon_f.loops[0].range_hit))
		else $error("loop 1 range flag not in bit 5");
	a_loop2_range_bit: assert property (
		##1 loop_ff[1][5] == $past(mon_f.loops[1].range_hit))
		else $error("loop 2 range flag not in bit 5");
	a_loop2_hold_bit: assert property (
		##1 loop_ff[1][1] == $past(mon_f.loops[1].holdover))
		else $error("loop 2 holdover flag not in bit 1");
	a_loop3_hold_bit: assert property (
		##1 loop_ff[2][1] == $past(mon_f.loops[2].holdover))
		else $error("loop 3 holdover flag not in bit 1");
	a_loop2_unlock_bit: assert property (
		##1 loop_ff[1][0] == $past(mon_f.loops[1].unlocked))
		else $error("loop 2 unlock flag not in bit 0");
	a_loop3_unlock_bit: assert property (
		##1 loop_ff[2][0] == $past(mon_f.loops[2].unlocked))
		else $error("loop 3 unlock flag not in bit 0");

	// flag meanings
	a_slope_below_limit: assert property (
		!mon_f.loops[2].slope_hit |=> !loop_ff[2][7])
		else $error("slope flag set below the limit");
	a_mem_over_limit: assert property (
		mon_f.loops[0].mem_hit |=> loop_ff[0][6])
		else $error("memory flag clear over the limit");
	a_range_within: assert property (
		!mon_f.loops[1].range_hit |=> !loop_ff[1][5])
		else $error("range flag set within range");
	a_hold_locked_zero: assert property (
		!mon_f.loops[2].holdover |=> !loop_ff[2][1])
		else $error("holdover flag set outside holdover");
	a_ref_loop2_nibble: assert property (
		##1 ref23_ff[3:0] == $past(mon_f.refs[2]))
		else $error("loop 2 reference nibble wrong");

	// synthesizer zero alignment and lock
	a_align_a_done: assert property (
		##1 synth_ff[4] == $past(mon_f.synth.align_done_a &
		mon_f.synth.out_a_enable & mon_f.synth.enable))
		else $error("divider A alignment flag wrong");
	a_align_a_pending: assert property (
		!mon_f.synth.align_done_a |=> !synth_ff[4])
		else $error("divider A flag set before alignment");
	a_align_b_done: assert property (
		##1 synth_ff[5] == $past(mon_f.synth.align_done_b &
		mon_f.synth.out_b_enable & mon_f.synth.enable))
		else $error("divider B alignment flag wrong");
	a_align_b_pending: assert property (
		!mon_f.synth.align_done_b |=> !synth_ff[5])
		else $error("divider B flag set before alignment");
	a_align_a_out_off: assert property (
		!mon_f.synth.out_a_enable |=> !synth_ff[4])
		else $error("divider A flag survives output disable");
	a_align_b_out_off: assert property (
		!mon_f.synth.out_b_enable |=> !synth_ff[5])
		else $error("divider B flag survives output disable");
	a_synth_lock_level: assert property (
		##1 synth_ff[2] == $past(mon_f.synth.unlocked))
		else $error("synthesizer unlock level wrong");

	// reset, reserved bits and reads
	a_reserved_other: assert property (
		loop_ff[1][4:2] == 3'h0 && loop_ff[2][4:2] == 3'h0)
		else $error("reserved loop bit nonzero");
	a_reset_clears: assert property (
		$fell(srst_i) |-> loop_ff == '0 && ref01_ff == 8'h00 &&
		ref23_ff == 8'h00 && synth_ff == 8'h00)
		else $error("bank not zero after reset");
	a_read_high_zero: assert property (
		prdata_o[31:8] == 24'h00_0000)
		else $error("read data upper bits nonzero");
	a_read_loop_byte: assert property (
		setup && hit_l2 |=> prdata_o == {24'h00_0000, $past(loop_ff[1])})
		else $error("loop 2 read data wrong");
	a_read_unmapped: assert property (
		setup && !hit_any |=> prdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	// interrupt status
	a_unlock_event_set: assert property (
		ev_unl[0] |=> irq_st_ff[0])
		else $error("loop 1 unlock event lost");

	c_loop_unlock_irq: cover property (ev_unl[0] ##1 irq_st_ff[0]);
	c_align_done: cover property ($rose(synth_ff[4]));
	c_unmapped_read: cover property (setup && !hit_any ##1 pslverr_o);
	c_irq_raised: cover property ($rose(irq_o));
	c_ref_update: cover property ($changed(ref23_ff));
endmodule

// ===== sim/test_loop_and_synth_status_bank.sv
// self-checking bench for the loop and synthesizer status bank
`timescale 1ns/1ps
`include "lssb_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
	miscompares++; $display("Error %s expected %h seen %h", nm, e, g); \
	end end
module test_loop_and_synth_status_bank;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	lssb_pkg::lssb_mon_t mon_i = '0;
	logic irq_o;
	int checks = 0;
	int miscompares = 0;
	logic [31:0] rd;
	logic er;
	int pos [5] = '{0, 1, 5, 6, 7};
	logic [5:0] syn [4] = '{6'h3D, 6'h3F, 6'h2F, 6'h1F};
	logic [7:0] sexp [4] = '{8'h14, 8'h34, 8'h24, 8'h04};

	lssb_top lssb_top_inst (
		.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .mon_i(mon_i), .irq_o(irq_o)
	);

	always #20 clk_i = ~clk_i;

	task end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one apb transfer, setup then access until pready
	task automatic apb(input logic w, input logic [9:0] idx,
			input logic [31:0] wd);
		int n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (pready_o !== 1'b1) begin
			miscompares++;
			end_sim;
		end else begin
			rd = prdata_o;
			er = pslverr_o;
			psel_i <= 1'b0;
			penable_i <= 1'b0;
		end
	endtask

	task automatic rchk(input logic [9:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 32'h0000_0000);
		`CHK("read data", {24'h000000, e}, rd)
		`CHK("read error", 1'b0, er)
	endtask

	task settle;
		repeat (8) @(posedge clk_i);
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		for (int r = 0; r < 3; r++) rchk(`LSSB_IDX_LOOP1 + r, 8'h00);
		rchk(`LSSB_IDX_REF01, 8'h00);
		rchk(`LSSB_IDX_REF23, 8'h00);
		rchk(`LSSB_IDX_SYNTH_ZERO, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			for (int k = 0; k < 5; k++) begin
				mon_i.loops[i] <= 5'h01 << k;
				settle;
				rchk(`LSSB_IDX_LOOP1 + i, 8'h01 << pos[k]);
			end
			mon_i.loops[i] <= '0;
		end
		$display("test loop flags done");
		mon_i.refs <= {4'hC, 4'h5, 4'hA, 4'h3};
		settle;
		rchk(`LSSB_IDX_REF01, 8'hA3);
		rchk(`LSSB_IDX_REF23, 8'hC5);
		$display("test references done");
		for (int s = 0; s < 4; s++) begin
			mon_i.synth <= syn[s];
			settle;
			rchk(`LSSB_IDX_SYNTH_ZERO, sexp[s]);
		end
		$display("test synthesizer done");
		apb(1'b1, `LSSB_IDX_LOOP1, 32'h0000_00FF);
		rchk(`LSSB_IDX_LOOP1, 8'h00);
		apb(1'b0, 10'h120, 32'h0000_0000);
		`CHK("unmapped error", 1'b1, er)
		`CHK("unmapped data", 32'h0000_0000, rd)
		$display("test writes done");
		mon_i <= '0;
		settle;
		rchk(`LSSB_IDX_IRQ_ST, 8'hFF);
		`CHK("irq masked", 1'b0, irq_o)
		apb(1'b1, `LSSB_IDX_IRQ_ST, 32'h0000_00FF);
		rchk(`LSSB_IDX_IRQ_ST, 8'h00);
		apb(1'b1, `LSSB_IDX_IRQ_MASK, 32'h0000_0001);
		rchk(`LSSB_IDX_IRQ_MASK, 8'h01);
		mon_i.loops[0].unlocked <= 1'b1;
		settle;
		`CHK("irq raised", 1'b1, irq_o)
		rchk(`LSSB_IDX_IRQ_ST, 8'h01);
		apb(1'b1, `LSSB_IDX_IRQ_MASK, 32'h0000_0000);
		settle;
		`CHK("irq unmasked off", 1'b0, irq_o)
		$display("test interrupts done");
		end_sim;
	end
endmodule
